// ### rtl/dbgc_cmd.v
// firmware-level command engine of the single-wire debug port
`include "dbgc_consts.vh"
module dbgc_cmd (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // background_debug_pin, open drain with speedup
  input  wire        background_debug_pin_in,
  output reg         background_debug_pin_out,
  output reg         background_debug_pin_oe,
  // debug control
  input  wire        ack_en,
  input  wire        enter_req,
  input  wire        insn_done,
  input  wire        cpu_wait_stop,
  output wire        dbg_active,
  output wire        cpu_halt,
  output reg         step_q,
  output reg         tag_en_q,
  // firmware page decode
  input  wire [15:0] cpu_addr,
  output wire        fw_map_hit,
  // cpu register file
  input  wire [15:0] pc_in,
  input  wire [15:0] d_in,
  input  wire [15:0] x_in,
  input  wire [15:0] y_in,
  input  wire [15:0] sp_in,
  output reg  [4:0]  reg_wr_q,
  output reg  [15:0] reg_wdata_q,
  // memory bus
  input  wire        bus_free,
  input  wire [15:0] mem_rdata,
  output reg         mem_req_q,
  output reg         mem_we_q,
  output reg  [15:0] mem_addr_q,
  output reg  [15:0] mem_wdata_q,
  output wire        cpu_freeze
);

  localparam [6:0] S_OPC  = 7'h01;
  localparam [6:0] S_DIN  = 7'h02;
  localparam [6:0] S_EXEC = 7'h04;
  localparam [6:0] S_MEM  = 7'h08;
  localparam [6:0] S_ACK  = 7'h10;
  localparam [6:0] S_TX   = 7'h20;
  localparam [6:0] S_RUN  = 7'h40;

  function [15:0] reg_pick;
    input [2:0] idx;
    begin
      case (idx)
        3'h0:    reg_pick = pc_in;
        3'h1:    reg_pick = d_in;
        3'h2:    reg_pick = x_in;
        3'h3:    reg_pick = y_in;
        default: reg_pick = sp_in;
      endcase
    end
  endfunction

  function [15:0] word_addr;
    input [15:0] a;
    begin
      word_addr = {a[15:1], 1'b0};
    end
  endfunction

  reg  [6:0]  st_q;
  reg  [6:0]  nxt_q;
  reg         in_d_q;
  reg         bit_act_q;
  reg  [4:0]  cyc_q;
  reg  [4:0]  nbits_q;
  reg  [15:0] sh_q;
  reg  [7:0]  op_q;
  reg  [9:0]  idle_q;
  reg  [5:0]  wt_q;
  reg  [7:0]  steal_cnt_q;
  reg         ack_q;
  reg         pend_ack_q;
  reg         stepping_q;
  reg  [4:0]  ack_cyc_q;
  wire        rx_st    = (st_q == S_OPC) || (st_q == S_DIN);
  wire        fall     = in_d_q & ~background_debug_pin_in & ~background_debug_pin_oe;
  wire        bit_end  = bit_act_q && (cyc_q == `DBGC_BIT_CYC - 5'h01);
  wire        last_bit = bit_end && (nbits_q == 5'h01);
  wire        steal    = (steal_cnt_q == `DBGC_STEAL_CYC);
  wire        grant    = mem_req_q && (bus_free || steal);
  wire [15:0] x_next   = x_in + `DBGC_STEP_ADD;
  wire [2:0]  rd_idx   = op_q[2:0] - 3'h3;
  wire        is_rd    = (op_q >= `DBGC_OP_RD_PC) && (op_q <= `DBGC_OP_RD_SP);
  wire        is_wr    = (op_q >= `DBGC_OP_WR_PC) && (op_q <= `DBGC_OP_WR_SP);

  assign dbg_active = (st_q != S_RUN);
  assign cpu_halt   = dbg_active;
  assign fw_map_hit = dbg_active && (cpu_addr[15:8] == `DBGC_FW_PAGE);
  assign cpu_freeze = mem_req_q && steal;

  ////////////////////////////////////////////////////////////////////////////
  // serial pin drive: reply bits and acknowledge pulse
  always @* begin
    background_debug_pin_out = 1'b0;
    background_debug_pin_oe  = 1'b0;
    if (st_q == S_TX && bit_act_q) begin
      if (!sh_q[15] && cyc_q < `DBGC_TX0_LOW_CYC) begin
        background_debug_pin_oe = 1'b1;
      end else if ((!sh_q[15] && cyc_q == `DBGC_TX0_LOW_CYC) ||
                   (sh_q[15] && cyc_q == `DBGC_TX1_SPEED_CYC)) begin
        background_debug_pin_oe  = 1'b1;
        background_debug_pin_out = 1'b1;
      end
    end else if (st_q == S_ACK && ack_q && wt_q == `DBGC_ACK_MIN_CYC) begin
      background_debug_pin_oe  = 1'b1;
      background_debug_pin_out = (ack_cyc_q == `DBGC_ACK_LOW_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit timing, shifting and command sequencing
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q        <= S_RUN;
      nxt_q       <= S_OPC;
      in_d_q      <= 1'b1;
      bit_act_q   <= 1'b0;
      cyc_q       <= 5'h00;
      nbits_q     <= 5'h00;
      sh_q        <= 16'h0000;
      op_q        <= 8'h00;
      idle_q      <= 10'h000;
      wt_q        <= 6'h00;
      steal_cnt_q <= 8'h00;
      ack_q       <= 1'b0;
      pend_ack_q  <= 1'b0;
      stepping_q  <= 1'b0;
      ack_cyc_q   <= 5'h00;
      step_q      <= 1'b0;
      tag_en_q    <= 1'b0;
      reg_wr_q    <= 5'h00;
      reg_wdata_q <= 16'h0000;
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 16'h0000;
    end else begin
      in_d_q   <= background_debug_pin_in;
      step_q   <= 1'b0;
      reg_wr_q <= 5'h00;
      if (wt_q != `DBGC_ACK_MIN_CYC) begin
        wt_q <= wt_q + 6'h01;
      end
      // per-bit timer, started by the host falling edge
      if (fall && !bit_act_q && (rx_st || st_q == S_TX)) begin
        bit_act_q <= 1'b1;
        cyc_q     <= 5'h00;
        idle_q    <= 10'h000;
      end else if (bit_act_q) begin
        cyc_q <= cyc_q + 5'h01;
        if (bit_end) begin
          bit_act_q <= 1'b0;
          nbits_q   <= nbits_q - 5'h01;
        end
      end else if (nbits_q != `DBGC_OPC_BITS && idle_q != `DBGC_TIMEOUT_CYC) begin
        idle_q <= idle_q + 10'h001;
      end
      if (bit_act_q && rx_st && cyc_q == `DBGC_SAMPLE_CYC) begin
        sh_q <= {sh_q[14:0], background_debug_pin_in};
      end
      if (bit_end && st_q == S_TX) begin
        sh_q <= {sh_q[14:0], 1'b0};
      end
      case (st_q)
        S_OPC: begin
          if (idle_q == `DBGC_TIMEOUT_CYC) begin
            nbits_q <= `DBGC_OPC_BITS;
            idle_q  <= 10'h000;
          end else if (last_bit) begin
            op_q  <= sh_q[7:0];
            wt_q  <= 6'h00;
            st_q  <= S_EXEC;
            ack_q <= ack_en;
          end
        end
        S_DIN: begin
          if (idle_q == `DBGC_TIMEOUT_CYC) begin
            st_q    <= S_OPC;
            nbits_q <= `DBGC_OPC_BITS;
            idle_q  <= 10'h000;
          end else if (last_bit) begin
            wt_q <= 6'h00;
            st_q <= S_EXEC;
          end
        end
        S_EXEC: begin
          nxt_q <= S_OPC;
          st_q  <= S_ACK;
          if (op_q == `DBGC_OP_RD_NEXT || op_q == `DBGC_OP_WR_NEXT) begin
            reg_wr_q    <= 5'h01 << `DBGC_IDX_X;
            reg_wdata_q <= x_next;
            mem_addr_q  <= word_addr(x_next);
            mem_we_q    <= op_q[5] == 1'b0;
            mem_wdata_q <= sh_q;
            mem_req_q   <= 1'b1;
            steal_cnt_q <= 8'h00;
            st_q        <= S_MEM;
          end else if (is_rd) begin
            sh_q  <= reg_pick(rd_idx);
            nxt_q <= S_TX;
          end else if (is_wr) begin
            reg_wr_q    <= 5'h01 << rd_idx;
            reg_wdata_q <= sh_q;
          end else if (op_q == `DBGC_OP_GO) begin
            nxt_q <= S_RUN;
          end else if (op_q == `DBGC_OP_GO_UNTIL || op_q == `DBGC_OP_STEP) begin
            pend_ack_q <= ack_q;
            stepping_q <= (op_q == `DBGC_OP_STEP);
            step_q     <= (op_q == `DBGC_OP_STEP);
            ack_q      <= 1'b0;
            nxt_q      <= S_RUN;
          end else if (op_q == `DBGC_OP_TAG_GO) begin
            tag_en_q   <= 1'b1;
            ack_q      <= 1'b0;
            pend_ack_q <= 1'b0;
            nxt_q      <= S_RUN;
          end else begin
            ack_q <= 1'b0;
          end
        end
        S_MEM: begin
          if (grant) begin
            mem_req_q <= 1'b0;
            if (!mem_we_q) begin
              sh_q  <= mem_rdata;
              nxt_q <= S_TX;
            end
            st_q <= S_ACK;
          end else if (!steal) begin
            steal_cnt_q <= steal_cnt_q + 8'h01;
          end
        end
        S_ACK: begin
          if (!ack_q) begin
            st_q      <= nxt_q;
            ack_cyc_q <= 5'h00;
          end else if (wt_q == `DBGC_ACK_MIN_CYC) begin
            if (ack_cyc_q == `DBGC_ACK_LOW_CYC) begin
              st_q      <= nxt_q;
              ack_cyc_q <= 5'h00;
            end else begin
              ack_cyc_q <= ack_cyc_q + 5'h01;
            end
          end
          nbits_q <= (nxt_q == S_TX) ? `DBGC_WORD_BITS : `DBGC_OPC_BITS;
        end
        S_TX: begin
          if (last_bit) begin
            st_q    <= S_OPC;
            nbits_q <= `DBGC_OPC_BITS;
          end
        end
        S_RUN: begin
          if (cpu_wait_stop) begin
            pend_ack_q <= 1'b0;
          end
          if ((stepping_q && insn_done) || (!stepping_q && enter_req)) begin
            st_q       <= S_ACK;
            nxt_q      <= S_OPC;
            ack_q      <= pend_ack_q && !cpu_wait_stop;
            pend_ack_q <= 1'b0;
            stepping_q <= 1'b0;
            wt_q       <= `DBGC_ACK_MIN_CYC;
          end
        end
        default: begin
          st_q <= S_RUN;
        end
      endcase
      // data-carrying opcodes take their 16-bit word before executing
      if (st_q == S_OPC && last_bit &&
          ((sh_q[7:0] >= `DBGC_OP_WR_NEXT) && (sh_q[7:0] <= `DBGC_OP_WR_SP))) begin
        st_q    <= S_DIN;
        nbits_q <= `DBGC_WORD_BITS;
      end
      if (st_q == S_ACK && nxt_q == S_RUN && !ack_q) begin
        steal_cnt_q <= 8'h00;
      end
    end
  end

endmodule // dbgc_cmd

// ### rtl/dbgc_consts.vh
// timing counts and command opcodes for the debug command engine
`ifndef DBGC_CONSTS_VH
`define DBGC_CONSTS_VH
`define DBGC_BIT_CYC       5'h10
`define DBGC_SAMPLE_CYC    5'h0a
`define DBGC_TX0_LOW_CYC   5'h0d
`define DBGC_TX1_SPEED_CYC 5'h07
`define DBGC_ACK_LOW_CYC   5'h10
`define DBGC_ACK_MIN_CYC   6'h20
`define DBGC_STEAL_CYC     8'h80
`define DBGC_TIMEOUT_CYC   10'h200
`define DBGC_OPC_BITS      5'h08
`define DBGC_WORD_BITS     5'h10
`define DBGC_FW_PAGE       8'hff
`define DBGC_OP_RD_NEXT    8'h62
`define DBGC_OP_RD_PC      8'h63
`define DBGC_OP_RD_SP      8'h67
`define DBGC_OP_WR_NEXT    8'h42
`define DBGC_OP_WR_PC      8'h43
`define DBGC_OP_WR_SP      8'h47
`define DBGC_OP_GO         8'h08
`define DBGC_OP_GO_UNTIL   8'h0c
`define DBGC_OP_STEP       8'h10
`define DBGC_OP_TAG_GO     8'h18
`define DBGC_IDX_X         3'h2
`define DBGC_STEP_ADD      16'h0002
`endif

// ### test/dbgc_checker.sv
// assertion checker for the debug command engine ports
module dbgc_checker (
  // clock and reset
  input wire        clk,
  input wire        arst_n,
  // serial pin drive
  input wire        background_debug_pin_out,
  input wire        background_debug_pin_oe,
  // debug control
  input wire        dbg_active,
  input wire        cpu_halt,
  input wire        step_q,
  // decode, registers and bus
  input wire [15:0] cpu_addr,
  input wire        fw_map_hit,
  input wire [4:0]  reg_wr_q,
  input wire        mem_req_q,
  input wire        bus_free
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire       lo = background_debug_pin_oe && !background_debug_pin_out;
  wire       hi = background_debug_pin_oe && background_debug_pin_out;
  reg  [8:0] wait_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      wait_q <= 9'h000;
    else
      wait_q <= mem_req_q ? wait_q + 9'h001 : 9'h000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // a low drive lasting past a reply bit must be the full acknowledge
  sequence ack_start; $rose(lo) ##1 lo [*8] ##1 lo [*5]; endsequence
  sequence ack_tail; lo [*2] ##1 hi; endsequence
  sequence wr_once; ($onehot(reg_wr_q) && dbg_active) ##1 (reg_wr_q == 5'h00); endsequence
  halt_follows_a: assert property (cpu_halt == dbg_active)
    else $error("cpu halt differs from debug state");
  fw_page_a: assert property (fw_map_hit == (dbg_active && cpu_addr[15:8] == 8'hff))
    else $error("firmware page decode wrong");
  quiet_run_a: assert property (!dbg_active |-> !background_debug_pin_oe)
    else $error("pin driven outside debug mode");
  ack_shape_a: assert property (ack_start |=> ack_tail)
    else $error("acknowledge pulse shape wrong");
  speedup_brief_a: assert property (hi |=> !hi)
    else $error("speedup pulse too long");
  wr_strobe_a: assert property (reg_wr_q != 5'h00 |-> wr_once)
    else $error("register write strobe wrong");
  step_pulse_a: assert property (step_q |=> !step_q)
    else $error("step pulse longer than one cycle");
  grant_drop_a: assert property (mem_req_q && bus_free |=> !mem_req_q)
    else $error("request held after free cycle");
  steal_bound_a: assert property (mem_req_q |-> wait_q <= 9'h082)
    else $error("bus cycle not stolen in time");
  mem_debug_a: assert property (mem_req_q |-> dbg_active)
    else $error("memory access outside debug mode");
endmodule // dbgc_checker
bind dbgc_cmd dbgc_checker u_chk (.*);

// ### test/dbgc_host.sv
// serial host pod model driving the background debug pin
module dbgc_host (
  // clock and pin level
  input  wire  clk,
  input  wire  pin,
  // open-drain low drive
  output logic drv_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial drv_low = 1'b0;
  // each bit opens with a falling edge, msb first, 18 cycles apart
  task put_bits(input int n, input logic [15:0] v);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk) drv_low = 1'b1;
      repeat (v[i] ? 2 : 13) @(negedge clk);
      drv_low = 1'b0;
      repeat (v[i] ? 15 : 4) @(negedge clk);
    end
  endtask
  task get_word(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk) drv_low = 1'b1;
      repeat (2) @(negedge clk);
      drv_low = 1'b0;
      repeat (8) @(negedge clk);
      w[i] = pin;
      repeat (7) @(negedge clk);
    end
  endtask
  // completion by handshake instead of fixed waits
  task wait_ack(input int lim, output bit got);
    got = 1'b0;
    repeat (lim) begin
      @(negedge clk);
      if (pin === 1'b0) begin
        got = 1'b1;
        break;
      end
    end
    if (got) repeat (40) begin
      @(negedge clk);
      if (pin === 1'b1) break;
    end
  endtask
endmodule // dbgc_host

// ### test/testbench.sv
// self-checking bench for the debug command engine
`include "dbgc_consts.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  $display("Error %s expected %h seen %h", n, e, g); bad_count++; end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, arst_n = 1'b0, ack_en = 1'b1, free_mode = 1'b1;
  logic        enter_req = 1'b0, insn_done = 1'b0, cpu_wait_stop = 1'b0, bus_free = 1'b0;
  logic [15:0] cpu_addr = 16'h0000, mem_rdata = 16'h0000;
  logic [15:0] rv [5];
  wire  [15:0] pc_in = rv[0], d_in = rv[1], x_in = rv[2], y_in = rv[3], sp_in = rv[4];
  wire         background_debug_pin_out, background_debug_pin_oe, dbg_active, cpu_halt, step_q, tag_en_q, fw_map_hit;
  wire         mem_req_q, mem_we_q, cpu_freeze, host_low;
  wire  [4:0]  reg_wr_q;
  wire  [15:0] reg_wdata_q, mem_addr_q, mem_wdata_q;
  wire         background_debug_pin_in = !(host_low || (background_debug_pin_oe && !background_debug_pin_out));
  logic [4:0]  wr_q = 5'h00;
  logic [15:0] wd_q = 16'h0000, ma_q = 16'h0000, mwd_q = 16'h0000;
  logic        mwe_q = 1'b0, frz_q = 1'b0, stp_q = 1'b0;
  int          bad_count = 0, checked = 0;
  dbgc_cmd DUT (.*);
  dbgc_host u_host (.clk(clk), .pin(background_debug_pin_in), .drv_low(host_low));
  always #10 clk = ~clk;
  always @(negedge clk) bus_free <= free_mode && ($urandom % 4 == 0);
  always @(posedge clk) begin
    if (reg_wr_q !== 5'h00) begin
      wr_q <= reg_wr_q;
      wd_q <= reg_wdata_q;
    end
    if (mem_req_q === 1'b1) begin
      ma_q <= mem_addr_q;
      mwe_q <= mem_we_q;
      mwd_q <= mem_wdata_q;
    end
    if (cpu_freeze === 1'b1) frz_q <= 1'b1;
    if (step_q === 1'b1) stp_q <= 1'b1;
  end
  function logic [15:0] nxt(input logic [15:0] x);
    return x + `DBGC_STEP_ADD;
  endfunction
  task finish_test;
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task pulse(input int s);
    @(negedge clk);
    case (s)
      0: enter_req = 1'b1;
      1: insn_done = 1'b1;
      default: cpu_wait_stop = 1'b1;
    endcase
    @(negedge clk);
    {enter_req, insn_done, cpu_wait_stop} = 3'h0;
  endtask
  task cmd(input logic [7:0] op, input bit wr, input logic [15:0] wd, input int lim,
           output bit got);
    u_host.put_bits(8, {8'h00, op});
    if (wr) u_host.put_bits(16, wd);
    u_host.wait_ack(lim, got);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    finish_test;
  end
  initial begin
    logic [15:0] w, d;
    bit          got;
    for (int k = 0; k < 5; k++) rv[k] = 16'h0000;
    void'($urandom(33));
    for (int k = 0; k < 5; k++) rv[k] = 16'($urandom);
    repeat (2) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    cmd(`DBGC_OP_RD_PC, 1'b0, 16'h0000, 100, got);
    `CHK("run ack", 1'b0, got)
    pulse(0);
    `CHK("halt", 1'b1, cpu_halt)
    cpu_addr = 16'hff00;
    #1 `CHK("page hit", 1'b1, fw_map_hit)
    cpu_addr = 16'hfeff;
    #1 `CHK("page miss", 1'b0, fw_map_hit)
    for (int k = 0; k < 5; k++) begin
      cmd(`DBGC_OP_RD_PC + 8'(k), 1'b0, 16'h0000, 400, got);
      u_host.get_word(w);
      `CHK("read ack", 1'b1, got)
      `CHK("read reg", rv[k], w)
    end
    for (int k = 0; k < 5; k++) begin
      d = 16'($urandom);
      cmd(`DBGC_OP_WR_PC + 8'(k), 1'b1, d, 400, got);
      `CHK("write ack", 1'b1, got)
      `CHK("write strobe", 5'h01 << k, wr_q)
      `CHK("write data", d, wd_q)
    end
    rv[2] = 16'($urandom) | 16'h0001;
    mem_rdata = 16'($urandom);
    free_mode = 1'b0;
    cmd(`DBGC_OP_RD_NEXT, 1'b0, 16'h0000, 600, got);
    u_host.get_word(w);
    `CHK("next data", mem_rdata, w)
    `CHK("next addr", nxt(rv[2]) & 16'hfffe, ma_q)
    `CHK("next index", nxt(rv[2]), wd_q)
    `CHK("stolen cycle", 1'b1, frz_q)
    free_mode = 1'b1;
    d = 16'($urandom);
    cmd(`DBGC_OP_WR_NEXT, 1'b1, d, 600, got);
    `CHK("store we", 1'b1, mwe_q)
    `CHK("store addr", nxt(rv[2]) & 16'hfffe, ma_q)
    `CHK("store data", d, mwd_q)
    ack_en = 1'b0;
    cmd(`DBGC_OP_RD_SP, 1'b0, 16'h0000, 44, got);
    u_host.get_word(w);
    `CHK("quiet read ack", 1'b0, got)
    `CHK("quiet read", rv[4], w)
    mem_rdata = 16'($urandom);
    cmd(`DBGC_OP_RD_NEXT, 1'b0, 16'h0000, 150, got);
    u_host.get_word(w);
    `CHK("quiet next", mem_rdata, w)
    d = 16'($urandom);
    cmd(`DBGC_OP_WR_NEXT, 1'b1, d, 150, got);
    `CHK("quiet store", d, mwd_q)
    d = 16'($urandom);
    cmd(`DBGC_OP_WR_SP, 1'b1, d, 32, got);
    `CHK("quiet write ack", 1'b0, got)
    `CHK("quiet write", d, wd_q)
    ack_en = 1'b1;
    cmd(`DBGC_OP_STEP, 1'b0, 16'h0000, 40, got);
    `CHK("early step ack", 1'b0, got)
    pulse(1);
    u_host.wait_ack(200, got);
    `CHK("step ack", 1'b1, got)
    `CHK("step pulse", 1'b1, stp_q)
    `CHK("step reentry", 1'b1, dbg_active)
    repeat (64) @(negedge clk);
    cmd(`DBGC_OP_GO_UNTIL, 1'b0, 16'h0000, 40, got);
    `CHK("early until ack", 1'b0, got)
    `CHK("until runs", 1'b0, dbg_active)
    pulse(0);
    u_host.wait_ack(200, got);
    `CHK("until ack", 1'b1, got)
    cmd(`DBGC_OP_GO_UNTIL, 1'b0, 16'h0000, 40, got);
    pulse(2);
    pulse(0);
    u_host.wait_ack(200, got);
    `CHK("wait stop ack", 1'b0, got)
    cmd(`DBGC_OP_TAG_GO, 1'b0, 16'h0000, 200, got);
    `CHK("tag ack", 1'b0, got)
    `CHK("tag enable", 1'b1, tag_en_q)
    pulse(0);
    repeat (100) @(negedge clk);
    cmd(`DBGC_OP_GO, 1'b0, 16'h0000, 200, got);
    `CHK("go ack", 1'b1, got)
    repeat (64) @(negedge clk);
    `CHK("go leaves", 1'b0, dbg_active)
    finish_test;
  end
endmodule // testbench
